// ===== verif/adcg_properties.sv
// port-level assertions for the converter control and gain block
`timescale 1ns/100ps
module adcg_properties
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timer1_overflow,
   input wire logic        timer2_overflow,
   input wire logic        external_convert_start,
   input wire logic        converter_power,
   input wire logic        burst_mode,
   input wire logic        conversion_start,
   input wire logic [11:0] gain_word,
   input wire logic [12:0] gain_effective
);
   // single clock domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // apb answer: one access cycle straight after setup, refusals return zero
   pready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   pready_single_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer with data or without pready");

   // a start pulse is single: no second start in the three cycles after it
   start_single_a: assert property (conversion_start |=> (!conversion_start) [*3])
      else $error("start pulse repeated");
   // every start has a cause: overflow or write one cycle back, pin rise two to five back
   start_cause_a: assert property (conversion_start |-> $past(timer1_overflow)
      || $past(timer2_overflow) || $past(pready && pwrite)
      || ($past(external_convert_start, 2) && !$past(external_convert_start, 6)))
      else $error("start without a trigger");

   // burst keeps the converter powered only while converting
   burst_power_a: assert property (conversion_start && burst_mode |=> converter_power)
      else $error("no power during burst conversion");
   burst_write_a: assert property ($changed(burst_mode) |->
      $past(pready && pwrite) || $past(pready && pwrite, 2))
      else $error("burst mode changed without a write");

   // gain in 1/4096 units: word plus an optional 64, never above 4159
   gain_sum_a: assert property ($stable(gain_word) && $stable(gain_effective) |->
      gain_effective == {1'b0, gain_word} || gain_effective == {1'b0, gain_word} + 13'h0040)
      else $error("effective gain not word plus fine term");
   gain_max_a: assert property (gain_effective <= 13'h103F)
      else $error("effective gain above range");
endmodule

bind adcg_top adcg_properties i_props
(
   .clk, .rstn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
   .timer1_overflow, .timer2_overflow, .external_convert_start,
   .converter_power, .burst_mode, .conversion_start, .gain_word, .gain_effective
);

// ===== verif/adcg_triggers.sv
// model of the timer overflow sources and the external start pin
`timescale 1ns/100ps
module adcg_triggers
(
   input  wire logic clk,
   output logic      timer1_overflow,
   output logic      timer2_overflow,
   output logic      external_convert_start
);
   // quiet lines from time zero
   initial
   begin
      timer1_overflow = 1'b0;
      timer2_overflow = 1'b0;
      external_convert_start = 1'b0;
   end

   // overflows are one-cycle pulses; the pin is a level held for hold cycles
   task automatic fire(input logic [1:0] src, input int hold);
      if (src == adcg_pkg::TRIG_EXTERNAL)
      begin
         external_convert_start <= 1'b1;
         repeat (hold) @(posedge clk);
         external_convert_start <= 1'b0;
      end
      else
      begin
         timer1_overflow <= (src == adcg_pkg::TRIG_TIMER1);
         timer2_overflow <= (src == adcg_pkg::TRIG_TIMER2);
         @(posedge clk);
         timer1_overflow <= 1'b0;
         timer2_overflow <= 1'b0;
      end
      @(posedge clk);
   endtask
endmodule

// ===== verif/test_adcg_top.sv
// self-checking bench for the converter control and gain block
`timescale 1ns/100ps
module test_adcg_top;
   localparam logic [7:0] CTL = adcg_pkg::OFS_ADC_CONTROL;
   localparam logic [7:0] STS = adcg_pkg::OFS_IRQ_STATUS;
   localparam logic [7:0] MSK = adcg_pkg::OFS_IRQ_MASK;
   localparam logic [7:0] GL  = adcg_pkg::OFS_GAIN_LOW;
   typedef struct {logic [7:0] gh; logic [7:0] gl; logic fa; logic [12:0] eff;} adcg_row_s;

   // gain rows: high, low, fine add, effective gain in 1/4096 units
   adcg_row_s   rows [7] = '{'{8'hFC, 8'h00, 1'b1, 13'h1000}, '{8'h7C, 8'h00, 1'b1, 13'h0800},
      '{8'hBC, 8'h00, 1'b1, 13'h0C00}, '{8'h3C, 8'h05, 1'b1, 13'h0400},
      '{8'hFF, 8'hF0, 1'b0, 13'h0FFF}, '{8'hFF, 8'hFA, 1'b1, 13'h103F},
      '{8'h00, 8'h00, 1'b0, 13'h0000}};
   logic [7:0]  rst_a [6] = '{CTL, 8'hF0, GL, 8'hF8, STS, MSK};
   logic [31:0] rst_v [6] = '{32'h0, 32'hFC, 32'h0, 32'h1, 32'h0, 32'h0};
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        window_match_event = 1'b0;
   logic [11:0] conversion_sample = 12'h000;
   logic [31:0] prdata, rdv;
   logic        pready, pslverr, erv, converter_power, burst_mode, conversion_start, irq;
   logic        timer1_overflow, timer2_overflow, external_convert_start;
   logic [11:0] gain_word, smp;
   logic [12:0] gain_effective;
   logic [7:0]  ctl;
   int          n_errors = 0;
   int          num_checks = 0;
   int          n_starts = 0;
   int          k;

   adcg_top i_dut
   (
      .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .timer1_overflow, .timer2_overflow, .external_convert_start,
      .window_match_event, .conversion_sample, .converter_power, .burst_mode,
      .conversion_start, .gain_word, .gain_effective, .irq
   );
   adcg_triggers i_src
   (
      .clk, .timer1_overflow, .timer2_overflow, .external_convert_start
   );

   // clock and start counter; counting pulses catches extra or missing starts
   initial forever #5 clk = ~clk;
   always @(posedge clk)
      if (conversion_start === 1'b1)
         n_starts <= n_starts + 1;

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task final_report;
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one apb transfer, held until pready; ends one idle edge later
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, rdv, x);
   endtask

   // software start keeps the trigger field at zero, others come from the model
   task automatic fire(input logic [1:0] m, input int hold);
      if (m == adcg_pkg::TRIG_SOFTWARE)
         apb(1'b1, CTL, {24'h0, ctl | 8'h10});
      else
         i_src.fire(m, hold);
   endtask

   task automatic window_pulse;
      window_match_event <= 1'b1;
      @(posedge clk);
      window_match_event <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   initial
   begin
      #100000;
      n_errors++;
      final_report();
   end

   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (rows[i])
      begin
         apb(1'b1, 8'hF0, {24'h0, rows[i].gh});
         apb(1'b1, GL, {24'h0, rows[i].gl});
         apb(1'b1, 8'hF8, {31'h0, rows[i].fa});
         rdc("gain low", GL, {24'h0, rows[i].gl[7:4], 4'h0});
         chk("gain word", {20'h0, gain_word}, {20'h0, rows[i].gh, rows[i].gl[7:4]});
         chk("gain", {19'h0, gain_effective}, {19'h0, rows[i].eff});
      end
      // second reset in mid-run restores the unity gain defaults
      rstn <= 1'b0;
      repeat (10) @(posedge clk);
      chk("reset gain", {19'h0, gain_effective}, 32'h1000);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (rst_a[i])
         rdc("reset value", rst_a[i], rst_v[i]);
      apb(1'b1, 8'h00, 32'hFF);
      chk("unmapped write", {31'h0, erv}, 32'h1);
      rdc("unmapped read", 8'h04, 32'h0);
      // each source: a wrong one is ignored, the right one starts once
      for (int m = 0; m < 4; m++)
      begin
         ctl = 8'h80 | 8'(m) | 8'((m & 1) << 2);
         smp = 12'hA50 + 12'(m);
         conversion_sample <= smp;
         apb(1'b1, CTL, {24'h0, ctl});
         apb(1'b1, MSK, 32'h1);
         k = n_starts;
         fire((m == 1) ? 2'h3 : (m == 3) ? 2'h2 : 2'h1, 4);
         repeat (8) @(posedge clk);
         chk("wrong source", n_starts, k);
         fire(2'(m), 9);
         for (int w = 0; w < 8 && n_starts == k; w++)
            @(posedge clk);
         rdc("busy", CTL, {24'h0, ctl | 8'h10});
         fire(2'(m), 4);
         for (int w = 0; w < 40 && irq !== 1'b1; w++)
            @(posedge clk);
         chk("starts", n_starts, k + 1);
         rdc("done", CTL, {24'h0, ctl | 8'h20});
         rdc("result", 8'hD8, m[0] ? {16'h0, smp, 4'h0} : {20'h0, smp});
         rdc("status", STS, 32'h1);
         apb(1'b1, STS, 32'h1);
         apb(1'b1, CTL, {24'h0, ctl});
         chk("irq clear", {31'h0, irq}, 32'h0);
      end
      // disabled, burst, then abort by clearing enable mid-conversion
      ctl = 8'h01;
      apb(1'b1, CTL, 32'h01);
      fire(2'h1, 1);
      repeat (4) @(posedge clk);
      chk("power off", {31'h0, converter_power}, 32'h0);
      chk("disabled start", n_starts, k + 1);
      apb(1'b1, CTL, 32'hC1);
      repeat (2) @(posedge clk);
      chk("burst idle", {30'h0, burst_mode, converter_power}, 32'h2);
      fire(2'h1, 1);
      repeat (2) @(posedge clk);
      chk("burst busy", {31'h0, converter_power}, 32'h1);
      apb(1'b1, CTL, 32'h01);
      repeat (20) @(posedge clk);
      rdc("abort", CTL, 32'h01);
      // window flag sets, stays, interrupts when unmasked only
      apb(1'b1, MSK, 32'h2);
      window_pulse();
      chk("window irq", {31'h0, irq}, 32'h1);
      rdc("window flag", CTL, 32'h09);
      rdc("window status", STS, 32'h2);
      apb(1'b1, MSK, 32'h0);
      window_pulse();
      chk("masked irq", {31'h0, irq}, 32'h0);
      apb(1'b1, CTL, 32'h0);
      rdc("window clear", CTL, 32'h0);
      final_report();
   end
endmodule

// ===== verilog/adcg_gain.sv
// gain word assembly and effective gain in units of 1/4096
`timescale 1ns/100ps
module adcg_gain
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  gain_high,
   input  wire logic [3:0]  gain_low_top,
   input  wire logic        gain_fine_add_bit,
   output logic      [11:0] gain_word,
   output logic      [12:0] gain_effective
);

   // ------------------------------------------------------------------
   // registered gain outputs
   // ------------------------------------------------------------------
   logic [11:0] next_gain_word;
   logic [12:0] next_gain_effective;
   // high byte first, then upper nibble of the low byte
   assign next_gain_word = {gain_high, gain_low_top};

   // fine add is one sixty-fourth, i.e. 64 of 4096; top 4095+64 gives 1.015
   assign next_gain_effective = {1'b0, next_gain_word}
                              + (gain_fine_add_bit ? adcg_pkg::GAIN_FINE_STEP
                                                   : 13'h0000);

   // reset state matches default settings: 4032 + 64 = unity
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gain_word      <= {adcg_pkg::RST_GAIN_HIGH, adcg_pkg::RST_GAIN_LOW};
         gain_effective <= adcg_pkg::RST_GAIN_EFF;
      end
      else
      begin
         gain_word      <= next_gain_word;
         gain_effective <= next_gain_effective;
      end
   end

endmodule

// ===== verilog/adcg_pkg.sv
// shared constants and types for the converter control and gain block
package adcg_pkg;

   // ------------------------------------------------------------------
   // register byte addresses on the apb bus
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_ADC_CONTROL = 8'hE8;
   localparam logic [7:0] OFS_GAIN_HIGH   = 8'hF0;
   localparam logic [7:0] OFS_GAIN_LOW    = 8'hF4;
   localparam logic [7:0] OFS_GAIN_FINE   = 8'hF8;
   localparam logic [7:0] OFS_RESULT      = 8'hD8;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'hD0;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'hD4;

   // ------------------------------------------------------------------
   // control register field positions, plus the fine add bit of the gain fine register
   // ------------------------------------------------------------------
   localparam int BIT_ENABLE  = 7;
   localparam int BIT_BURST   = 6;
   localparam int BIT_DONE    = 5;
   localparam int BIT_BUSY    = 4;
   localparam int BIT_WINDOW  = 3;
   localparam int BIT_LJUST   = 2;
   localparam int TRIG_MSB    = 1;
   localparam int TRIG_LSB    = 0;
   localparam int BIT_FINE    = 0;

   // interrupt status and mask layout
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_WINDOW  = 1;

   // ------------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_ADC_CONTROL = 8'h00;
   localparam logic [7:0] RST_GAIN_HIGH   = 8'hFC;
   localparam logic [3:0] RST_GAIN_LOW    = 4'h0;
   localparam logic       RST_GAIN_FINE   = 1'b1;
   localparam logic [1:0] RST_IRQ         = 2'h0;
   localparam logic [12:0] RST_GAIN_EFF   = 13'h1000;

   // ------------------------------------------------------------------
   // start-of-conversion sources
   // ------------------------------------------------------------------
   localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
   localparam logic [1:0] TRIG_TIMER1   = 2'h1;
   localparam logic [1:0] TRIG_EXTERNAL = 2'h2;
   localparam logic [1:0] TRIG_TIMER2   = 2'h3;

   // ------------------------------------------------------------------
   // timing and gain arithmetic
   // ------------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         CONV_TIME_NS  = 160;
   localparam int         CONV_CYCLES_I = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CONV_CYCLES   = 8'(CONV_CYCLES_I);
   localparam logic [12:0] GAIN_FINE_STEP = 13'h0040;

   typedef enum logic {st_idle, st_convert} adcg_state_e;

endpackage

// ===== verilog/adcg_top.sv
// converter control, start trigger selection, gain and apb registers
//
// What this block does
// - bit 6 turns burst operation on when set, off when cleared
// - done flag bit 5 sets when a conversion ends, stays until software clears
// - writing 1 to busy starts a conversion only with trigger field 00
// - trigger field 01: each timer 1 overflow starts a conversion
// - trigger field 10: rising edge on the external start pin starts one
// - trigger field 11: each timer 2 overflow starts a conversion
// - window flag bit 3 sets on a window match, only software clears it
// - bit 2 set gives left-justified result, clear gives right-justified
// - gain word is gain high byte followed by gain low bits 7:4
// - fine add bit 0 adds one sixty-fourth to the gain
// - gain is word over 4096 plus fine term; defaults give unity
// - reachable gain spans 0 up to 1.015
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module adcg_top
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer1_overflow,
   input  wire logic        timer2_overflow,
   input  wire logic        external_convert_start,
   input  wire logic        window_match_event,
   input  wire logic [11:0] conversion_sample,
   output logic             converter_power,
   output logic             burst_mode,
   output logic             conversion_start,
   output logic      [11:0] gain_word,
   output logic      [12:0] gain_effective,
   output logic             irq
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic                   converter_enable_bit;
   logic                   burst_enable_bit;
   logic                   conversion_done_flag;
   logic                   window_match_flag;
   logic                   left_justify_select;
   logic [1:0]             start_trigger_select;
   logic [7:0]             gain_high_reg;
   logic [3:0]             gain_low_top;
   logic                   gain_fine_add_bit;
   logic [15:0]            result_reg;
   logic [1:0]             irq_status;
   logic [1:0]             irq_mask;
   adcg_pkg::adcg_state_e  state;
   logic [7:0]             conv_count;
   logic                   ext_sync_a;
   logic                   ext_sync_b;
   logic                   ext_prev;

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   logic        bus_write;
   logic        bus_setup;
   logic        ctrl_write;
   logic        busy;
   logic        ext_rise;
   logic        trigger_hit;
   logic        start_req;
   logic        conv_end;
   logic [7:0]  ctrl_read;

   // true when the address names a register of this block
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == adcg_pkg::OFS_ADC_CONTROL) || (a == adcg_pkg::OFS_GAIN_HIGH)
                 || (a == adcg_pkg::OFS_GAIN_LOW)    || (a == adcg_pkg::OFS_GAIN_FINE)
                 || (a == adcg_pkg::OFS_RESULT)      || (a == adcg_pkg::OFS_IRQ_STATUS)
                 || (a == adcg_pkg::OFS_IRQ_MASK);
   endfunction

   // write strobe for one register at the completing edge
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs,
                                    input logic wr);
      reg_hit = wr && (a == ofs);
   endfunction

   // write only takes effect at the edge where the access completes
   assign bus_write  = psel && penable && pready && pwrite;
   assign bus_setup  = psel && !penable;
   assign ctrl_write = reg_hit(paddr, adcg_pkg::OFS_ADC_CONTROL, bus_write);
   assign busy       = (state == adcg_pkg::st_convert);

   // ------------------------------------------------------------------
   // external start pin synchroniser
   // ------------------------------------------------------------------
   // pin is asynchronous; edge detect only looks past the second flop
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ext_sync_a <= 1'b0;
         ext_sync_b <= 1'b0;
         ext_prev   <= 1'b0;
      end
      else
      begin
         ext_sync_a <= external_convert_start;
         ext_sync_b <= ext_sync_a;
         ext_prev   <= ext_sync_b;
      end
   end

   assign ext_rise = ext_sync_b && !ext_prev;

   // ------------------------------------------------------------------
   // start trigger selection
   // ------------------------------------------------------------------
   // software start uses the trigger field being written with it
   always_comb
   begin
      trigger_hit = 1'b0;
      unique case (start_trigger_select)
         adcg_pkg::TRIG_SOFTWARE: trigger_hit = 1'b0;
         adcg_pkg::TRIG_TIMER1:   trigger_hit = timer1_overflow;
         adcg_pkg::TRIG_EXTERNAL: trigger_hit = ext_rise;
         adcg_pkg::TRIG_TIMER2:   trigger_hit = timer2_overflow;
      endcase
      if (ctrl_write && pwdata[adcg_pkg::BIT_BUSY]
          && pwdata[adcg_pkg::TRIG_MSB:adcg_pkg::TRIG_LSB] == adcg_pkg::TRIG_SOFTWARE)
      begin
         trigger_hit = 1'b1;
      end
   end

   // triggers during a conversion or with the converter off are dropped
   assign start_req = trigger_hit && converter_enable_bit && !busy;
   assign conv_end  = busy && (conv_count == 8'h01);

   // ------------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------------
   // disabling mid-conversion aborts it with no done flag
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state      <= adcg_pkg::st_idle;
         conv_count <= 8'h00;
      end
      else
      begin
         unique case (state)
            adcg_pkg::st_idle:
            begin
               if (start_req)
               begin
                  state      <= adcg_pkg::st_convert;
                  conv_count <= adcg_pkg::CONV_CYCLES;
               end
            end
            adcg_pkg::st_convert:
            begin
               if (!converter_enable_bit || conv_end)
               begin
                  state      <= adcg_pkg::st_idle;
                  conv_count <= 8'h00;
               end
               else
               begin
                  conv_count <= conv_count - 8'h01;
               end
            end
         endcase
      end
   end

   // one-cycle start pulse to the analog front end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         conversion_start <= 1'b0;
      end
      else
      begin
         conversion_start <= start_req;
      end
   end

   // result captured with the justification chosen at the end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         result_reg <= 16'h0000;
      end
      else if (conv_end)
      begin
         result_reg <= left_justify_select ? {conversion_sample, 4'h0}
                                           : {4'h0, conversion_sample};
      end
   end

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         converter_enable_bit <= adcg_pkg::RST_ADC_CONTROL[adcg_pkg::BIT_ENABLE];
         burst_enable_bit     <= adcg_pkg::RST_ADC_CONTROL[adcg_pkg::BIT_BURST];
         conversion_done_flag <= adcg_pkg::RST_ADC_CONTROL[adcg_pkg::BIT_DONE];
         window_match_flag    <= adcg_pkg::RST_ADC_CONTROL[adcg_pkg::BIT_WINDOW];
         left_justify_select  <= adcg_pkg::RST_ADC_CONTROL[adcg_pkg::BIT_LJUST];
         start_trigger_select <= adcg_pkg::RST_ADC_CONTROL[adcg_pkg::TRIG_MSB:adcg_pkg::TRIG_LSB];
      end
      else
      begin
         if (ctrl_write)
         begin
            converter_enable_bit <= pwdata[adcg_pkg::BIT_ENABLE];
            burst_enable_bit     <= pwdata[adcg_pkg::BIT_BURST];
            left_justify_select  <= pwdata[adcg_pkg::BIT_LJUST];
            start_trigger_select <= pwdata[adcg_pkg::TRIG_MSB:adcg_pkg::TRIG_LSB];
         end
         if (conv_end)
         begin
            conversion_done_flag <= 1'b1;
         end
         else if (ctrl_write)
         begin
            conversion_done_flag <= pwdata[adcg_pkg::BIT_DONE];
         end
         if (window_match_event)
         begin
            window_match_flag <= 1'b1;
         end
         else if (ctrl_write)
         begin
            window_match_flag <= pwdata[adcg_pkg::BIT_WINDOW];
         end
      end
   end

   // ------------------------------------------------------------------
   // gain registers
   // ------------------------------------------------------------------
   // low nibble of the gain low register is not stored and reads zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gain_high_reg     <= adcg_pkg::RST_GAIN_HIGH;
         gain_low_top      <= adcg_pkg::RST_GAIN_LOW;
         gain_fine_add_bit <= adcg_pkg::RST_GAIN_FINE;
      end
      else
      begin
         if (reg_hit(paddr, adcg_pkg::OFS_GAIN_HIGH, bus_write))
         begin
            gain_high_reg <= pwdata[7:0];
         end
         if (reg_hit(paddr, adcg_pkg::OFS_GAIN_LOW, bus_write))
         begin
            gain_low_top <= pwdata[7:4];
         end
         if (reg_hit(paddr, adcg_pkg::OFS_GAIN_FINE, bus_write))
         begin
            gain_fine_add_bit <= pwdata[adcg_pkg::BIT_FINE];
         end
      end
   end

   adcg_gain u_gain
   (
      .clk               (clk),
      .rstn              (rstn),
      .gain_high         (gain_high_reg),
      .gain_low_top      (gain_low_top),
      .gain_fine_add_bit (gain_fine_add_bit),
      .gain_word         (gain_word),
      .gain_effective    (gain_effective)
   );

   // ------------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------------
   // write one to clear; a new event in the clearing cycle keeps its bit
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_status <= adcg_pkg::RST_IRQ;
         irq_mask   <= adcg_pkg::RST_IRQ;
      end
      else
      begin
         if (reg_hit(paddr, adcg_pkg::OFS_IRQ_MASK, bus_write))
         begin
            irq_mask <= pwdata[1:0];
         end
         if (reg_hit(paddr, adcg_pkg::OFS_IRQ_STATUS, bus_write))
         begin
            irq_status <= (irq_status & ~pwdata[1:0]) | {window_match_event, conv_end};
         end
         else
         begin
            irq_status <= irq_status | {window_match_event, conv_end};
         end
      end
   end

   // ------------------------------------------------------------------
   // registered outputs to the analog side and the core
   // ------------------------------------------------------------------
   // burst keeps the converter powered only while it converts, saving power
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         converter_power <= 1'b0;
         burst_mode      <= 1'b0;
         irq             <= 1'b0;
      end
      else
      begin
         converter_power <= converter_enable_bit && (!burst_enable_bit || busy);
         burst_mode      <= burst_enable_bit;
         irq             <= |(irq_status & irq_mask);
      end
   end

   // ------------------------------------------------------------------
   // apb slave: no wait states, read data captured in the setup cycle
   // ------------------------------------------------------------------
   assign ctrl_read = {converter_enable_bit, burst_enable_bit, conversion_done_flag,
                       busy, window_match_flag, left_justify_select,
                       start_trigger_select};

   // registered answer adds no wait state, since it is formed in the setup cycle, and keeps every output on a flop
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (bus_setup)
      begin
         pready  <= 1'b1;
         pslverr <= !addr_mapped(paddr);
         prdata  <= 32'h0000_0000;
         if (!pwrite)
         begin
            unique case (1'b1)
               (paddr == adcg_pkg::OFS_ADC_CONTROL): prdata <= {24'h00_0000, ctrl_read};
               (paddr == adcg_pkg::OFS_GAIN_HIGH):   prdata <= {24'h00_0000, gain_high_reg};
               (paddr == adcg_pkg::OFS_GAIN_LOW):    prdata <= {24'h00_0000, gain_low_top, 4'h0};
               (paddr == adcg_pkg::OFS_GAIN_FINE):   prdata <= {31'h0000_0000, gain_fine_add_bit};
               (paddr == adcg_pkg::OFS_RESULT):      prdata <= {16'h0000, result_reg};
               (paddr == adcg_pkg::OFS_IRQ_STATUS):  prdata <= {30'h0000_0000, irq_status};
               (paddr == adcg_pkg::OFS_IRQ_MASK):    prdata <= {30'h0000_0000, irq_mask};
               default:                              prdata <= 32'h0000_0000;
            endcase
         end
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule
